// ==== include/mrs_pkg.sv ====
// package for the rotate, skip and subtract execution datapath
package mrs_pkg;

  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] MRS_ADDR_ACC = 8'h00;
  localparam logic [7:0] MRS_ADDR_STATUS = 8'h04;
  localparam logic [7:0] MRS_ADDR_OPERAND = 8'h08;
  localparam logic [7:0] MRS_ADDR_TABLE = 8'h0C;
  localparam logic [7:0] MRS_ADDR_COMMAND = 8'h10;
  localparam logic [7:0] MRS_ADDR_RESULT = 8'h14;
  localparam logic [7:0] MRS_ADDR_TBL_HIGH = 8'h18;

  // field positions
  localparam int MRS_TABLE_PAGE_LSB = 8;
  localparam int MRS_CMD_W = 5;

  // reset values
  localparam logic [7:0] MRS_ACC_RST = 8'h00;
  localparam logic [3:0] MRS_FLAGS_RST = 4'h0;

  // ahb constants
  localparam logic [2:0] MRS_HSIZE_WORD = 3'b010;
  localparam logic [1:0] MRS_HRESP_OKAY = 2'b00;

  // status layout: c bit 0, half carry bit 1, z bit 2, overflow bit 3
  typedef struct packed {
    logic signed_range_exceed_flag;
    logic zero;
    logic half_carry_flag;
    logic carry;
  } mrs_flags_t;

  // operand register: memory byte [7:0], immediate [15:8], bit [18:16]
  typedef struct packed {
    logic [2:0] bit_sel;
    logic [7:0] imm;
    logic [7:0] mem;
  } mrs_operand_t;

  // result register without the live busy bit
  typedef struct packed {
    logic refused;
    logic skip;
    logic mem_wr;
    logic [7:0] mem;
  } mrs_result_t;

  // operation codes, numbered from 0 in this order
  typedef enum logic [MRS_CMD_W-1:0] {
    op_none,
    op_rotate_left_through_carry,
    op_rotate_left_carry_to_accumulator,
    op_rotate_right_plain,
    op_rotate_right_to_accumulator,
    op_rotate_right_through_carry,
    op_rotate_right_carry_to_accumulator,
    op_rotate_left_plain_to_accumulator,
    op_subtract_with_borrow,
    op_subtract_borrow_into_memory,
    op_subtract_memory,
    op_subtract_immediate,
    op_subtract_into_memory,
    op_decrement_skip_if_zero,
    op_decrement_skip_result_accumulator,
    op_increment_skip_if_zero,
    op_increment_skip_result_accumulator,
    op_set_byte,
    op_set_bit,
    op_skip_if_bit_set,
    op_skip_if_bit_clear,
    op_skip_if_zero_test,
    op_copy_skip_if_zero,
    op_nibble_swap,
    op_nibble_swap_to_accumulator,
    op_table_read_current_page,
    op_table_read_last_page,
    op_xor_memory,
    op_xor_immediate,
    op_xor_into_memory
  } mrs_op_t;

  // sequencer states
  typedef enum logic [2:0] {
    st_idle, st_exec, st_dummy, st_fetch, st_capture
  } mrs_state_t;

endpackage : mrs_pkg

// ==== rtl/mrs_core.sv ====
// execution datapath for rotate, subtract, skip, set, swap, table and xor
// Overview of operation
// - left rotate through carry, only carry changes
// - plain right rotate, bit 0 to 7, flags kept
// - right rotate through carry, only carry changes
// - accumulator forms leave memory byte untouched
// - acc minus memory minus inverted carry, four flags
// - carry cleared on negative, set otherwise
// - plain subtract of memory or immediate, four flags
// - decrement memory, store, skip on zero
// - decrement into accumulator, skip on zero
// - increment memory or accumulator, skip on zero
// - every skip operation takes two cycles
// - byte set writes all ones, flags kept
// - bit set forces one selected bit
// - skip when selected bit is one
// - skip when selected bit is zero
// - skip when whole byte is zero
// - copy byte to accumulator, skip on zero
// - swap nibbles to memory or accumulator
// - current page table read, low and high
// - last page table read at pointer offset
// - xor to accumulator or memory, zero only
`timescale 1ns/1ps
`default_nettype none
module mrs_core #(
  parameter int PC_W = 11,
  parameter int WORD_W = 15,
  parameter int TP_W = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  output logic [PC_W-1:0] prog_addr,
  input wire logic [WORD_W-1:0] prog_word,
  output logic [mrs_pkg::MRS_CMD_W-1:0] busy_op
);
  import mrs_pkg::*;

  localparam int PG_W = PC_W - TP_W;
  localparam int HI_W = WORD_W - 8;

  // the page field sits right above the pointer byte in the table word,
  // so the pointer must be exactly one byte wide to read back as written
  if (PG_W < 1 || TP_W != MRS_TABLE_PAGE_LSB || PC_W > 24 || HI_W < 1 ||
      WORD_W > 32) begin : g_geometry_check
    $error("mrs_core: unsupported program memory geometry");
  end

  logic [7:0] acc;
  mrs_flags_t flags;
  mrs_operand_t opnd;
  logic [TP_W-1:0] tbl_ptr;
  logic [PG_W-1:0] cur_page;
  mrs_op_t cmd;
  mrs_state_t st;
  mrs_result_t res;
  logic [HI_W-1:0] tbl_high;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic cmd_wr;
  logic busy;
  logic [7:0] nres;
  logic to_acc;
  logic to_mem;
  logic skip;
  mrs_flags_t nfl;

  // register index from a byte address; 7 means unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      MRS_ADDR_ACC: reg_index = 3'h0;
      MRS_ADDR_STATUS: reg_index = 3'h1;
      MRS_ADDR_OPERAND: reg_index = 3'h2;
      MRS_ADDR_TABLE: reg_index = 3'h3;
      MRS_ADDR_COMMAND: reg_index = 3'h4;
      MRS_ADDR_RESULT: reg_index = 3'h5;
      MRS_ADDR_TBL_HIGH: reg_index = 3'h6;
      default: reg_index = 3'h7;
    endcase
  endfunction : reg_index

  // difference plus flags: {overflow, half carry, carry, result}
  function automatic logic [10:0] sub_calc(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic bin);
    logic [8:0] d;
    logic [4:0] lo;
    d = {1'b0, a} - {1'b0, b} - {8'h00, bin};
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
    // carry is an inverted borrow: 0 on a negative result
    sub_calc = {(a[7] ^ b[7]) & (a[7] ^ d[7]), ~lo[4], ~d[8], d[7:0]};
  endfunction : sub_calc

  // operations that skip need the extra dummy cycle
  function automatic logic is_skip(input mrs_op_t op);
    case (op)
      op_decrement_skip_if_zero, op_decrement_skip_result_accumulator,
      op_increment_skip_if_zero, op_increment_skip_result_accumulator,
      op_skip_if_bit_set, op_skip_if_bit_clear, op_skip_if_zero_test,
      op_copy_skip_if_zero: is_skip = 1'b1;
      default: is_skip = 1'b0;
    endcase
  endfunction : is_skip

  // zero-wait slave: no stalls, always an okay answer
  assign hreadyout = 1'b1;
  assign hresp = MRS_HRESP_OKAY;
  assign busy = (st != st_idle);
  assign busy_op = busy ? cmd : op_none;
  assign cmd_wr = wr_pend && (reg_index(wr_addr) == 3'h4);

  // address phase capture for writes; non-word writes are dropped
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite &&
                 (hsize == MRS_HSIZE_WORD) && (haddr[31:8] == 24'h000000);
      wr_addr <= haddr[7:0];
    end
  end

  // read data registered in the address phase, valid in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (hsel && hready && htrans[1] && !hwrite) begin
      hrdata <= 32'h00000000;
      if (haddr[31:8] == 24'h000000) begin
        case (reg_index(haddr[7:0]))
          3'h0: hrdata[7:0] <= acc;
          3'h1: hrdata[3:0] <= flags;
          3'h2: hrdata[18:0] <= opnd;
          3'h3: hrdata[PC_W-1:0] <= {cur_page, tbl_ptr};
          3'h4: hrdata[MRS_CMD_W-1:0] <= cmd;
          3'h5: hrdata[11:0] <= {res.refused, busy, res.skip, res.mem_wr,
                                 res.mem};
          3'h6: hrdata[HI_W-1:0] <= tbl_high;
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // operand and table pointer registers, software only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opnd <= '0;
      tbl_ptr <= '0;
      cur_page <= '0;
    end else if (wr_pend) begin
      if (reg_index(wr_addr) == 3'h2) begin
        opnd <= hwdata[18:0];
      end
      if (reg_index(wr_addr) == 3'h3) begin
        tbl_ptr <= hwdata[TP_W-1:0];
        cur_page <= hwdata[MRS_TABLE_PAGE_LSB +: PG_W];
      end
    end
  end

  // operation result; the datapath never looks at st itself
  always_comb begin
    logic [10:0] sd;
    logic [7:0] bm;
    sd = 11'h000;
    bm = 8'h01 << opnd.bit_sel;
    nres = opnd.mem;
    to_acc = 1'b0;
    to_mem = 1'b0;
    skip = 1'b0;
    nfl = flags;
    case (cmd)
      op_rotate_left_through_carry,
      op_rotate_left_carry_to_accumulator: begin
        {nfl.carry, nres} = {opnd.mem, flags.carry};
        to_mem = (cmd == op_rotate_left_through_carry);
        to_acc = !to_mem;
      end
      op_rotate_right_plain, op_rotate_right_to_accumulator: begin
        nres = {opnd.mem[0], opnd.mem[7:1]};
        to_mem = (cmd == op_rotate_right_plain);
        to_acc = !to_mem;
      end
      op_rotate_right_through_carry,
      op_rotate_right_carry_to_accumulator: begin
        {nres, nfl.carry} = {flags.carry, opnd.mem};
        to_mem = (cmd == op_rotate_right_through_carry);
        to_acc = !to_mem;
      end
      op_rotate_left_plain_to_accumulator: begin
        nres = {opnd.mem[6:0], opnd.mem[7]};
        to_acc = 1'b1;
      end
      op_subtract_with_borrow, op_subtract_borrow_into_memory,
      op_subtract_memory, op_subtract_immediate,
      op_subtract_into_memory: begin
        // borrow only for the carry forms, immediate only for one
        sd = sub_calc(acc,
                      (cmd == op_subtract_immediate) ? opnd.imm : opnd.mem,
                      ((cmd == op_subtract_with_borrow) ||
                       (cmd == op_subtract_borrow_into_memory)) &&
                      !flags.carry);
        nres = sd[7:0];
        nfl.signed_range_exceed_flag = sd[10];
        nfl.half_carry_flag = sd[9];
        nfl.carry = sd[8];
        nfl.zero = (sd[7:0] == 8'h00);
        to_mem = (cmd == op_subtract_borrow_into_memory) ||
                 (cmd == op_subtract_into_memory);
        to_acc = !to_mem;
      end
      op_decrement_skip_if_zero, op_decrement_skip_result_accumulator: begin
        nres = opnd.mem - 8'h01;
        skip = (nres == 8'h00);
        to_mem = (cmd == op_decrement_skip_if_zero);
        to_acc = !to_mem;
      end
      op_increment_skip_if_zero, op_increment_skip_result_accumulator: begin
        nres = opnd.mem + 8'h01;
        skip = (nres == 8'h00);
        to_mem = (cmd == op_increment_skip_if_zero);
        to_acc = !to_mem;
      end
      op_set_byte: begin
        nres = 8'hFF;
        to_mem = 1'b1;
      end
      op_set_bit: begin
        nres = opnd.mem | bm;
        to_mem = 1'b1;
      end
      op_skip_if_bit_set: skip = |(opnd.mem & bm);
      op_skip_if_bit_clear: skip = ~|(opnd.mem & bm);
      op_skip_if_zero_test: skip = (opnd.mem == 8'h00);
      op_copy_skip_if_zero: begin
        skip = (opnd.mem == 8'h00);
        to_acc = 1'b1;
      end
      op_nibble_swap, op_nibble_swap_to_accumulator: begin
        nres = {opnd.mem[3:0], opnd.mem[7:4]};
        to_mem = (cmd == op_nibble_swap);
        to_acc = !to_mem;
      end
      op_xor_memory, op_xor_immediate, op_xor_into_memory: begin
        nres = acc ^ ((cmd == op_xor_immediate) ? opnd.imm : opnd.mem);
        nfl.zero = (nres == 8'h00);
        to_mem = (cmd == op_xor_into_memory);
        to_acc = !to_mem;
      end
      default: nres = opnd.mem;
    endcase
  end

  // sequencer: a skip holds busy over a dummy cycle, a table read
  // waits one cycle for the synchronous program memory
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= st_idle;
    end else begin
      case (st)
        st_idle: if (cmd_wr) st <= st_exec;
        st_exec: begin
          if (cmd == op_table_read_current_page ||
              cmd == op_table_read_last_page) begin
            st <= st_fetch;
          end else if (is_skip(cmd)) begin
            st <= st_dummy;
          end else begin
            st <= st_idle;
          end
        end
        st_fetch: st <= st_capture;
        st_capture: st <= st_idle;
        st_dummy: st <= st_idle;
        default: st <= st_idle;
      endcase
    end
  end

  // command register: a write while busy is refused, not queued
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd <= op_none;
    end else if (cmd_wr && !busy) begin
      cmd <= mrs_op_t'(hwdata[MRS_CMD_W-1:0]);
    end
  end

  // accumulator: the executing operation wins over a software write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= MRS_ACC_RST;
    end else if (st == st_exec && to_acc) begin
      acc <= nres;
    end else if (wr_pend && reg_index(wr_addr) == 3'h0) begin
      acc <= hwdata[7:0];
    end
  end

  // flags: same priority as the accumulator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags <= MRS_FLAGS_RST;
    end else if (st == st_exec) begin
      flags <= nfl;
    end else if (wr_pend && reg_index(wr_addr) == 3'h1) begin
      flags <= hwdata[3:0];
    end
  end

  // result register; memory byte is unchanged unless mem_wr is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res <= '0;
    end else begin
      if (cmd_wr) begin
        res.refused <= busy;
      end
      if (st == st_exec) begin
        res.mem <= to_mem ? nres : opnd.mem;
        res.mem_wr <= to_mem;
        res.skip <= skip;
      end else if (st == st_capture) begin
        res.mem <= prog_word[7:0];
        res.mem_wr <= 1'b1;
      end
    end
  end

  // table address: current page or the all-ones last page
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_addr <= '0;
    end else if (st == st_exec) begin
      prog_addr <= {(cmd == op_table_read_last_page) ? {PG_W{1'b1}} :
                    cur_page, tbl_ptr};
    end
  end

  // high part of the program word for software to read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tbl_high <= '0;
    end else if (st == st_capture) begin
      tbl_high <= prog_word[WORD_W-1:8];
    end
  end

  // checks; helper wires give $past plain signals
  logic [7:0] m_in;
  logic [7:0] ror_exp;
  logic [7:0] sw_exp;
  logic [8:0] sub_exp;
  logic sel_bit;
  assign m_in = opnd.mem;
  assign ror_exp = {opnd.mem[0], opnd.mem[7:1]};
  assign sw_exp = {opnd.mem[3:0], opnd.mem[7:4]};
  assign sel_bit = opnd.mem[opnd.bit_sel];
  assign sub_exp = {1'b0, acc} - {1'b0, opnd.mem} - {8'h00, !flags.carry};

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_ROT_LEFT_CARRY_MEM: assert property (
    st == st_exec && cmd == op_rotate_left_through_carry |=>
      {flags.carry, res.mem} == {$past(m_in), $past(flags.carry)} &&
      res.mem_wr && flags.zero == $past(flags.zero))
    else $error("left rotate through carry wrong");
  AST_ROT_RIGHT_FLAGS: assert property (
    st == st_exec && cmd == op_rotate_right_plain |=>
      res.mem == $past(ror_exp) && flags == $past(flags))
    else $error("plain right rotate wrong");
  AST_ROT_RIGHT_CARRY_ACC: assert property (
    st == st_exec && cmd == op_rotate_right_carry_to_accumulator |=>
      {acc, flags.carry} == {$past(flags.carry), $past(m_in)} &&
      !res.mem_wr)
    else $error("right rotate through carry to acc wrong");
  AST_SUB_BORROW_ACC: assert property (
    st == st_exec && cmd == op_subtract_with_borrow |=>
      acc == $past(sub_exp[7:0]) && flags.carry == !$past(sub_exp[8]))
    else $error("subtract with borrow wrong");
  AST_SKIP_TWO: assert property (
    st == st_exec && is_skip(cmd) |=> busy ##1 !busy)
    else $error("skip not two cycles");
  AST_SET_BYTE: assert property (
    st == st_exec && cmd == op_set_byte |=>
      res.mem == 8'hFF && res.mem_wr && $stable(flags))
    else $error("byte set wrong");
  AST_BIT_SKIP: assert property (
    st == st_exec && cmd == op_skip_if_bit_set |=>
      res.skip == $past(sel_bit) && !res.mem_wr)
    else $error("bit set skip wrong");
  AST_SWAP_ACC: assert property (
    st == st_exec && cmd == op_nibble_swap_to_accumulator |=>
      acc == $past(sw_exp) && !res.mem_wr)
    else $error("nibble swap to acc wrong");
  AST_TABLE_LAST: assert property (
    st == st_exec && cmd == op_table_read_last_page |=>
      prog_addr[PC_W-1:TP_W] == {PG_W{1'b1}} ##2 res.mem_wr && !busy)
    else $error("last page table read wrong");
  AST_XOR_ZERO: assert property (
    st == st_exec && cmd == op_xor_memory |=>
      flags.zero == (acc == 8'h00) &&
      flags.carry == $past(flags.carry))
    else $error("xor zero flag wrong");

  COV_SKIP_TAKEN: cover property (st == st_exec && skip && is_skip(cmd));
  COV_BORROW: cover property (st == st_exec && cmd == op_subtract_memory
                              && !nfl.carry);
  COV_TABLE: cover property (st == st_capture);
  COV_REFUSED: cover property (cmd_wr && busy);

endmodule : mrs_core
`default_nettype wire

// ==== verif/mcu_rotate_skip_sub_ops_tb.sv ====
// self-checking bench for the rotate, skip and subtract datapath
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module mcu_rotate_skip_sub_ops_tb;
  import mrs_pkg::*;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic [1:0] hresp;
  logic [31:0] hrdata, d;
  logic [10:0] prog_addr;
  logic [14:0] prog_word;
  logic [4:0] busy_op, cur_op;
  int cyc, error_cnt, checks;

  mrs_core mrs_core_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .prog_addr(prog_addr),
    .prog_word(prog_word), .busy_op(busy_op));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  // program word depends on every address bit so a wrong page shows up
  function automatic logic [14:0] pw(input logic [10:0] x);
    return {x[10:4], x[7:0] ^ {x[10:8], 5'h0C}};
  endfunction : pw

  // synchronous program memory, one cycle of latency
  always @(posedge hclk) prog_word <= pw(prog_addr);

  // busy length and the code shown while busy; skipped in reset, where
  // the sequencer may still be unknown before its first reset edge
  always @(posedge hclk) if (hresetn && busy_op !== 5'h00) begin
    cyc <= cyc + 1;
    `CHK(busy_op, cur_op)
  end

  // one single ahb transfer; caller stands just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [2:0] size,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= size;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, MRS_HSIZE_WORD, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, a, 32'h00000000, MRS_HSIZE_WORD, v);
  endtask : rd

  // operands lean on the boundary values of the byte
  function automatic logic [7:0] pick();
    case ($urandom_range(0, 4))
      0: return 8'h00;
      1: return 8'hFF;
      2: return 8'h80;
      3: return 8'h01;
      default: return 8'($urandom);
    endcase
  endfunction : pick

  // drive one operation and compare with the reference model
  task automatic run_op(input logic [4:0] op);
    logic [7:0] m, im, a, r, b, tp, e_acc, e_mem;
    logic [2:0] bs, pg;
    logic [3:0] f, e_fl;
    logic [14:0] w;
    logic [31:0] v;
    logic e_wr, e_sk;
    int full, low, bor, e_cyc;
    m = pick();
    im = pick();
    a = pick();
    bs = 3'($urandom);
    pg = 3'($urandom);
    tp = 8'($urandom);
    f = 4'($urandom);
    wr(MRS_ADDR_OPERAND, {13'h0000, bs, im, m});
    wr(MRS_ADDR_TABLE, {21'h000000, pg, tp});
    wr(MRS_ADDR_ACC, {24'h000000, a});
    wr(MRS_ADDR_STATUS, {28'h0000000, f});
    e_acc = a;
    e_fl = f;
    e_mem = m;
    e_wr = 1'b0;
    e_sk = 1'b0;
    e_cyc = 1;
    r = 8'h00;
    w = pw({(op == 5'd26) ? 3'h7 : pg, tp});
    case (op)
      5'd1, 5'd2: begin r = {m[6:0], f[0]}; e_fl[0] = m[7]; end
      5'd3, 5'd4: r = {m[0], m[7:1]};
      5'd5, 5'd6: begin r = {f[0], m[7:1]}; e_fl[0] = m[0]; end
      5'd7: r = {m[6:0], m[7]};
      5'd8, 5'd9, 5'd10, 5'd11, 5'd12: begin
        b = (op == 5'd11) ? im : m;
        bor = (op <= 5'd9 && f[0] == 1'b0) ? 1 : 0;
        full = int'(a) - int'(b) - bor;
        low = int'(a[3:0]) - int'(b[3:0]) - bor;
        r = 8'(full);
        e_fl = {(a[7] ^ b[7]) & (a[7] ^ r[7]), r == 8'h00,
                low >= 0, full >= 0};
      end
      5'd13, 5'd14: begin r = m - 8'h01; e_sk = r == 8'h00; e_cyc = 2; end
      5'd15, 5'd16: begin r = m + 8'h01; e_sk = r == 8'h00; e_cyc = 2; end
      5'd17: r = 8'hFF;
      5'd18: r = m | (8'h01 << bs);
      5'd19: begin e_sk = m[bs]; e_cyc = 2; end
      5'd20: begin e_sk = !m[bs]; e_cyc = 2; end
      5'd21: begin e_sk = m == 8'h00; e_cyc = 2; end
      5'd22: begin r = m; e_sk = m == 8'h00; e_cyc = 2; end
      5'd23, 5'd24: r = {m[3:0], m[7:4]};
      5'd25, 5'd26: begin r = w[7:0]; e_cyc = 3; end
      5'd27, 5'd29: r = a ^ m;
      5'd28: r = a ^ im;
      default: ;
    endcase
    if (op >= 5'd27 && op <= 5'd29) e_fl[2] = r == 8'h00;
    if (op inside {2, 4, 6, 7, 8, 10, 11, 14, 16, 22, 24, 27, 28}) e_acc = r;
    if (op inside {1, 3, 5, 9, 12, 13, 15, 17, 18, 23, 25, 26, 29}) begin
      e_wr = 1'b1;
      e_mem = r;
    end
    cur_op = op;
    cyc = 0;
    wr(MRS_ADDR_COMMAND, {27'h0000000, op});
    do rd(MRS_ADDR_RESULT, v); while (v[10] !== 1'b0);
    `CHK(cyc, e_cyc)
    rd(MRS_ADDR_RESULT, v);
    `CHK(v[11:8], {2'b00, e_sk, e_wr})
    `CHK(v[7:0], e_mem)
    rd(MRS_ADDR_ACC, v);
    `CHK(v[7:0], e_acc)
    rd(MRS_ADDR_STATUS, v);
    `CHK(v[3:0], e_fl)
    if (e_cyc == 3) begin
      rd(MRS_ADDR_TBL_HIGH, v);
      `CHK(v[6:0], w[14:8])
    end
  endtask : run_op

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude

  // a hang is cut short well beyond the expected run length
  initial begin
    repeat (60000) @(posedge hclk);
    error_cnt++;
    $display("ERROR t=%0t got %0h exp %0h", $time, 0, 1);
    conclude();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = MRS_HSIZE_WORD;
    hwdata = 32'h00000000;
    cur_op = 5'h00;
    cyc = 0;
    error_cnt = 0;
    checks = 0;
    void'($urandom(32'hDF8F1C38));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rd(MRS_ADDR_ACC, d);
    `CHK(d, 32'h00000000)
    rd(MRS_ADDR_STATUS, d);
    `CHK(d, 32'h00000000)
    rd(MRS_ADDR_RESULT, d);
    `CHK(d, 32'h00000000)
    $display("test reset values done");
    // every code except op_none, including the two spare ones, several times over
    for (int rep = 0; rep < 8; rep++)
      for (int op = 1; op < 32; op++) run_op(5'(op));
    $display("test operation sweep done");
    // a command written while a table read is still running is dropped
    wr(MRS_ADDR_TABLE, 32'h00000000);
    cur_op = 5'd25;
    wr(MRS_ADDR_COMMAND, 32'h00000019);
    wr(MRS_ADDR_COMMAND, 32'h00000015);
    do rd(MRS_ADDR_RESULT, d); while (d[10] !== 1'b0);
    rd(MRS_ADDR_RESULT, d);
    `CHK(d[11], 1'b1)
    `CHK(d[7:0], pw(11'h000) & 15'h00FF)
    $display("test refused command done");
    // byte-sized write and unmapped place leave state alone
    wr(MRS_ADDR_ACC, 32'h0000005A);
    bus(1'b1, MRS_ADDR_ACC, 32'h000000A5, 3'b000, d);
    rd(MRS_ADDR_ACC, d);
    `CHK(d[7:0], 8'h5A)
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, d);
    `CHK(d, 32'h00000000)
    `CHK(hresp, MRS_HRESP_OKAY)
    $display("test bus corner cases done");
    conclude();
  end
endmodule : mcu_rotate_skip_sub_ops_tb
`default_nettype wire
